// ### core/sli_regs.vh
// Purpose: constants for the simplex link init/status block
// Assumes: 100 MHz user clock, 32-bit register bus words
// Notes:   definitions only
`ifndef SLI_REGS_VH
`define SLI_REGS_VH

// ****************************************
// clock and timing
// ****************************************
`define SLI_CLK_PERIOD_NS    10
`define SLI_ALIGN_WAIT_US    20
`define SLI_BOND_WAIT_US     20
`define SLI_VERIFY_WAIT_US   40
`define SLI_REINIT_US        10000
`define SLI_WDOG_US          160
`define SLI_RESTART_HOLD_CYC 4
`define SLI_US_TO_CYC(t)     (((t) * 1000) / `SLI_CLK_PERIOD_NS)

// ****************************************
// register map (byte addresses)
// ****************************************
`define SLI_ADDR_W         4
`define SLI_OFS_CTRL       4'h0
`define SLI_OFS_STATUS     4'h4
`define SLI_OFS_LANES      4'h8
`define SLI_OFS_SOFTCNT    4'hc
`define SLI_CTRL_RST       3'h0
`define SLI_CTRL_TIMER     0
`define SLI_CTRL_TXRST     1
`define SLI_CTRL_REINIT    2
`define SLI_CTRL_W         3
`define SLI_CNT_W          16
`define SLI_CNT_MAX        16'hffff
`define SLI_LANE_FIELD     16

// ****************************************
// state codes
// ****************************************
`define SLI_ST_W   3
`define SLI_ST_RST 3'h0
`define SLI_ST_ALN 3'h1
`define SLI_ST_BND 3'h2
`define SLI_ST_VER 3'h3
`define SLI_ST_UP  3'h4

`endif

// ### core/sli_endpoint.v
// Purpose: init/status logic of a combined simplex endpoint
// Assumes: one user clock; per-direction sync resets
// Notes:   transmit and receive directions are independent

`include "sli_regs.vh"

module sli_endpoint #(
	parameter LANES      = 2,
	parameter ALIGN_CYC  = `SLI_US_TO_CYC(`SLI_ALIGN_WAIT_US),
	parameter BOND_CYC   = `SLI_US_TO_CYC(`SLI_BOND_WAIT_US),
	parameter VERIFY_CYC = `SLI_US_TO_CYC(`SLI_VERIFY_WAIT_US),
	parameter REINIT_CYC = `SLI_US_TO_CYC(`SLI_REINIT_US),
	parameter WDOG_CYC   = `SLI_US_TO_CYC(`SLI_WDOG_US)
) (
	input  wire                   clk,
	input  wire                   reset,
	input  wire                   tx_system_reset,
	input  wire                   rx_system_reset,
	input  wire                   power_down_in,
	input  wire                   tx_hard_err_in,
	input  wire                   rx_hard_err_in,
	input  wire                   sender_lanes_aligned_in,
	input  wire                   sender_bonding_in,
	input  wire                   sender_verified_in,
	input  wire                   sender_restart_in,
	input  wire [0:LANES-1]       tx_gt_lane_ok,
	input  wire                   tx_user_valid_in,
	input  wire [0:LANES-1]       rx_gt_lane_locked,
	input  wire                   rx_bond_done_in,
	input  wire                   rx_verify_done_in,
	input  wire [0:LANES-1]       rx_code_err_in,
	input  wire                   rx_frame_err_in,
	input  wire                   rx_user_valid_in,
	input  wire [`SLI_ADDR_W-1:0] avs_address,
	input  wire                   avs_read,
	input  wire                   avs_write,
	input  wire [31:0]            avs_writedata,
	output reg  [31:0]            avs_readdata,
	output reg                    avs_waitrequest,
	output reg                    gt_power_down,
	output reg                    tx_channel_ready,
	output reg  [0:LANES-1]       tx_lane_ready,
	output reg                    tx_send_enable,
	output reg                    receiver_lanes_aligned_out,
	output reg                    receiver_bonding_out,
	output reg                    receiver_verified_out,
	output reg                    receiver_restart_out,
	output reg                    rx_channel_ready,
	output reg  [0:LANES-1]       rx_lane_ready,
	output reg                    rx_user_valid,
	output reg                    rx_soft_err,
	output reg                    rx_frame_err
);

	localparam [31:0] ALIGN_LIM  = ALIGN_CYC;
	localparam [31:0] BOND_LIM   = BOND_CYC;
	localparam [31:0] VERIFY_LIM = VERIFY_CYC;
	localparam [31:0] REINIT_LIM = REINIT_CYC;
	localparam [31:0] WDOG_LIM   = WDOG_CYC;
	localparam [31:0] HOLD_LIM   = `SLI_RESTART_HOLD_CYC;
	localparam        MULTI      = (LANES > 1);

	// ****************************************
	// register bus
	// ****************************************
	reg  [`SLI_CTRL_W-1:0] ctrl_r;
	reg  [`SLI_CNT_W-1:0]  softcnt_r;
	wire                   bus_req;
	wire                   bus_wr;
	wire                   cnt_clr;
	reg  [31:0]            rd_nxt;

	assign bus_req = avs_read | avs_write;
	assign bus_wr  = avs_write & ~avs_waitrequest;
	assign cnt_clr = bus_wr && (avs_address == `SLI_OFS_SOFTCNT);

	// one wait cycle, then the answer edge
	always @(posedge clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			ctrl_r          <= `SLI_CTRL_RST;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= rd_nxt;
			if (bus_wr && (avs_address == `SLI_OFS_CTRL))
				ctrl_r <= avs_writedata[`SLI_CTRL_W-1:0];
		end
	end

	// ****************************************
	// partner sideband synchronisers
	// ****************************************
	wire [2:0] sb_pin;
	reg  [2:0] sb_s1_r;
	reg  [2:0] sb_s2_r;
	reg  [2:0] sb_s3_r;
	reg  [2:0] sb_r;

	assign sb_pin = {sender_verified_in, sender_bonding_in,
	                 sender_lanes_aligned_in};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sb
			always @(posedge clk) begin
				if (reset | tx_system_reset) begin
					sb_s1_r[g] <= 1'b0;
					sb_s2_r[g] <= 1'b0;
					sb_s3_r[g] <= 1'b0;
					sb_r[g]    <= 1'b0;
				end else begin
					sb_s1_r[g] <= sb_pin[g];
					sb_s2_r[g] <= sb_s1_r[g];
					sb_s3_r[g] <= sb_s2_r[g];
					if (sb_s2_r[g] == sb_s3_r[g])
						sb_r[g] <= sb_s3_r[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// transmit direction
	// ****************************************
	reg  [`SLI_ST_W-1:0] tx_st_r;
	reg  [`SLI_ST_W-1:0] tx_st_nxt;
	reg  [31:0]          tx_tmr_r;
	wire                 tx_rst;
	wire                 timer_mode;
	wire                 tx_aln_ok;
	wire                 tx_bnd_ok;
	wire                 tx_ver_ok;

	assign timer_mode = ctrl_r[`SLI_CTRL_TIMER];
	// own hard error only; receive side plays no part
	assign tx_rst = reset | tx_system_reset | tx_hard_err_in
	              | sender_restart_in
	              | ctrl_r[`SLI_CTRL_TXRST];
	assign tx_aln_ok = timer_mode ? (tx_tmr_r >= ALIGN_LIM) : sb_r[0];
	assign tx_bnd_ok = timer_mode ? (tx_tmr_r >= BOND_LIM) : sb_r[1];
	assign tx_ver_ok = timer_mode ? (tx_tmr_r >= VERIFY_LIM) : sb_r[2];

	always @* begin
		tx_st_nxt = tx_st_r;
		case (tx_st_r)
			`SLI_ST_RST: begin
				tx_st_nxt = `SLI_ST_ALN;
			end
			`SLI_ST_ALN: begin
				if (tx_aln_ok)
					tx_st_nxt = MULTI ? `SLI_ST_BND : `SLI_ST_VER;
			end
			`SLI_ST_BND: begin
				if (tx_bnd_ok)
					tx_st_nxt = `SLI_ST_VER;
			end
			`SLI_ST_VER: begin
				if (tx_ver_ok)
					tx_st_nxt = `SLI_ST_UP;
			end
			`SLI_ST_UP: begin
				// timer partner cannot ask for a restart, so reinit
				if (timer_mode && ctrl_r[`SLI_CTRL_REINIT] &&
				    (tx_tmr_r >= REINIT_LIM))
					tx_st_nxt = `SLI_ST_RST;
				else if (!timer_mode && !sb_r[0])
					tx_st_nxt = `SLI_ST_RST;
			end
			default: begin
				tx_st_nxt = `SLI_ST_RST;
			end
		endcase
	end

	always @(posedge clk) begin
		if (tx_rst) begin
			tx_st_r          <= `SLI_ST_RST;
			tx_tmr_r         <= 32'h0000_0000;
			tx_channel_ready <= 1'b0;
			tx_send_enable   <= 1'b0;
		end else begin
			tx_st_r <= tx_st_nxt;
			if (tx_st_nxt != tx_st_r)
				tx_tmr_r <= 32'h0000_0000;
			else if (tx_tmr_r != 32'hffff_ffff)
				tx_tmr_r <= tx_tmr_r + 32'h0000_0001;
			tx_channel_ready <= (tx_st_nxt == `SLI_ST_UP);
			tx_send_enable   <= (tx_st_nxt == `SLI_ST_UP) &&
			                    (&tx_gt_lane_ok) && tx_user_valid_in;
		end
	end

	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_txl
			always @(posedge clk) begin
				if (tx_rst)
					tx_lane_ready[g] <= 1'b0;
				else
					tx_lane_ready[g] <= tx_gt_lane_ok[g] &&
					    (tx_st_nxt != `SLI_ST_RST) &&
					    (tx_st_nxt != `SLI_ST_ALN);
			end
		end
	endgenerate

	// ****************************************
	// receive direction
	// ****************************************
	reg  [`SLI_ST_W-1:0] rx_st_r;
	reg  [`SLI_ST_W-1:0] rx_st_nxt;
	reg  [31:0]          rx_tmr_r;
	wire                 rx_rst;
	wire                 rx_all_lk;
	wire                 rx_wdog;

	assign rx_rst    = reset | rx_system_reset | rx_hard_err_in;
	assign rx_all_lk = &rx_gt_lane_locked;
	assign rx_wdog   = (rx_tmr_r >= WDOG_LIM);

	always @* begin
		rx_st_nxt = rx_st_r;
		case (rx_st_r)
			`SLI_ST_RST: begin
				if (rx_tmr_r + 32'h0000_0001 >= HOLD_LIM)
					rx_st_nxt = `SLI_ST_ALN;
			end
			`SLI_ST_ALN: begin
				if (rx_all_lk)
					rx_st_nxt = MULTI ? `SLI_ST_BND : `SLI_ST_VER;
				else if (rx_wdog)
					rx_st_nxt = `SLI_ST_RST;
			end
			`SLI_ST_BND: begin
				if (!rx_all_lk || rx_wdog)
					rx_st_nxt = `SLI_ST_RST;
				else if (rx_bond_done_in)
					rx_st_nxt = `SLI_ST_VER;
			end
			`SLI_ST_VER: begin
				if (!rx_all_lk || rx_wdog)
					rx_st_nxt = `SLI_ST_RST;
				else if (rx_verify_done_in)
					rx_st_nxt = `SLI_ST_UP;
			end
			`SLI_ST_UP: begin
				if (!rx_all_lk)
					rx_st_nxt = `SLI_ST_RST;
			end
			default: begin
				rx_st_nxt = `SLI_ST_RST;
			end
		endcase
	end

	// sideband outputs always driven, used or not
	always @(posedge clk) begin
		if (rx_rst) begin
			rx_st_r                    <= `SLI_ST_RST;
			rx_tmr_r                   <= 32'h0000_0000;
			rx_channel_ready           <= 1'b0;
			receiver_lanes_aligned_out <= 1'b0;
			receiver_bonding_out       <= 1'b0;
			receiver_verified_out      <= 1'b0;
			receiver_restart_out       <= 1'b1;
			rx_user_valid              <= 1'b0;
			rx_soft_err                <= 1'b0;
			rx_frame_err               <= 1'b0;
		end else begin
			rx_st_r <= rx_st_nxt;
			if (rx_st_nxt != rx_st_r)
				rx_tmr_r <= 32'h0000_0000;
			else if (rx_tmr_r != 32'hffff_ffff)
				rx_tmr_r <= rx_tmr_r + 32'h0000_0001;
			receiver_lanes_aligned_out <= (rx_st_nxt >= `SLI_ST_BND);
			receiver_bonding_out       <= MULTI &&
			                              (rx_st_nxt >= `SLI_ST_VER);
			receiver_verified_out      <= (rx_st_nxt == `SLI_ST_UP);
			receiver_restart_out       <= (rx_st_nxt == `SLI_ST_RST);
			rx_channel_ready           <= (rx_st_nxt == `SLI_ST_UP);
			rx_user_valid              <= rx_user_valid_in && rx_all_lk &&
			                              (rx_st_r == `SLI_ST_UP);
			rx_soft_err                <= |rx_code_err_in;
			rx_frame_err               <= rx_frame_err_in;
		end
	end

	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_rxl
			always @(posedge clk) begin
				if (rx_rst)
					rx_lane_ready[g] <= 1'b0;
				else
					rx_lane_ready[g] <= rx_gt_lane_locked[g] &&
					                    (rx_st_nxt != `SLI_ST_RST);
			end
		end
	endgenerate

	// ****************************************
	// soft error counter and power-down
	// ****************************************
	always @(posedge clk) begin
		if (rx_rst) begin
			softcnt_r <= {`SLI_CNT_W{1'b0}};
		end else if (rx_soft_err) begin
			// an error in the clear cycle survives the clear
			if (cnt_clr)
				softcnt_r <= {{(`SLI_CNT_W-1){1'b0}}, 1'b1};
			else if (softcnt_r != `SLI_CNT_MAX)
				softcnt_r <= softcnt_r + 1'b1;
		end else if (cnt_clr) begin
			softcnt_r <= {`SLI_CNT_W{1'b0}};
		end
	end

	always @(posedge clk) begin
		if (reset)
			gt_power_down <= 1'b0;
		else
			gt_power_down <= power_down_in;
	end

	// ****************************************
	// read mux
	// ****************************************
	integer k;
	always @* begin
		rd_nxt = 32'h0000_0000;
		case (avs_address)
			`SLI_OFS_CTRL: begin
				rd_nxt[`SLI_CTRL_W-1:0] = ctrl_r;
			end
			`SLI_OFS_STATUS: begin
				rd_nxt[0]   = tx_channel_ready;
				rd_nxt[1]   = rx_channel_ready;
				rd_nxt[2]   = receiver_lanes_aligned_out;
				rd_nxt[3]   = receiver_bonding_out;
				rd_nxt[4]   = receiver_verified_out;
				rd_nxt[5]   = receiver_restart_out;
				rd_nxt[10:8]  = tx_st_r;
				rd_nxt[14:12] = rx_st_r;
			end
			`SLI_OFS_LANES: begin
				for (k = 0; k < LANES; k = k + 1) begin
					rd_nxt[k] = rx_lane_ready[k];
					rd_nxt[k + `SLI_LANE_FIELD] = tx_lane_ready[k];
				end
			end
			`SLI_OFS_SOFTCNT: begin
				rd_nxt[`SLI_CNT_W-1:0] = softcnt_r;
			end
			default: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

endmodule // sli_endpoint

// ### verification/sli_endpoint_sva.sv
// Purpose: port assertions for the simplex link endpoint
// Assumes: one user clock, reset synchronous active high
// Notes:   bound into every sli_endpoint instance
// ****
// checker
// ****
module sli_endpoint_sva #(
	parameter LANES = 2
) (
	input logic             clk,
	input logic             reset,
	input logic             tx_system_reset,
	input logic             rx_system_reset,
	input logic             tx_hard_err_in,
	input logic             rx_hard_err_in,
	input logic             power_down_in,
	input logic             sender_restart_in,
	input logic             sender_verified_in,
	input logic [0:LANES-1] tx_gt_lane_ok,
	input logic             tx_user_valid_in,
	input logic [0:LANES-1] rx_gt_lane_locked,
	input logic [0:LANES-1] rx_code_err_in,
	input logic             rx_frame_err_in,
	input logic             rx_user_valid_in,
	input logic             gt_power_down,
	input logic             tx_channel_ready,
	input logic             tx_send_enable,
	input logic             receiver_lanes_aligned_out,
	input logic             receiver_bonding_out,
	input logic             receiver_verified_out,
	input logic             receiver_restart_out,
	input logic             rx_channel_ready,
	input logic             rx_user_valid,
	input logic             rx_soft_err,
	input logic             rx_frame_err,
	input logic [3:0]       avs_address,
	input logic             avs_write,
	input logic [31:0]      avs_writedata,
	input logic             avs_waitrequest
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// timer mode as software last wrote it; sideband status is ignored then, but sender_restart_in still resets tx
	logic tmr_mode_r;
	always @(posedge clk) begin
		if (reset)
			tmr_mode_r <= 1'b0;
		else if (avs_write && !avs_waitrequest && (avs_address == 4'h0))
			tmr_mode_r <= avs_writedata[0];
	end

	AST_PWR_FOLLOW: assert property (!$past(reset) |-> gt_power_down == $past(power_down_in))
		else $error("power-down not passed on");
	AST_FRAME_ONE: assert property (!$past(reset || rx_system_reset || rx_hard_err_in) |-> rx_frame_err == $past(rx_frame_err_in))
		else $error("frame error pulse wrong");
	AST_SOFT_EACH: assert property (!$past(reset || rx_system_reset || rx_hard_err_in) |-> rx_soft_err == $past(|rx_code_err_in))
		else $error("soft error not per error cycle");
	AST_TX_RESTART: assert property (sender_restart_in |-> ##2 !tx_channel_ready)
		else $error("tx ready survived restart");
	AST_TX_RESET: assert property ((tx_system_reset || tx_hard_err_in) |-> ##2 !tx_channel_ready)
		else $error("tx ready survived tx reset");
	AST_RX_RESET: assert property ((rx_system_reset || rx_hard_err_in) |-> ##2 (!rx_channel_ready && receiver_restart_out))
		else $error("rx not restarted by rx reset");
	AST_RX_LOCK: assert property (!(&rx_gt_lane_locked) |=> !receiver_lanes_aligned_out)
		else $error("aligned kept after lock loss");
	AST_RX_ORDER: assert property (receiver_verified_out |-> (receiver_bonding_out && receiver_lanes_aligned_out && rx_channel_ready))
		else $error("verified without earlier stages");
	AST_RX_DELIVER: assert property (rx_user_valid |-> $past(rx_user_valid_in && (&rx_gt_lane_locked)))
		else $error("rx data without all lanes");
	AST_TX_SEND: assert property (tx_send_enable |-> $past(tx_user_valid_in && (&tx_gt_lane_ok)))
		else $error("tx send without all lanes");
	AST_TX_SRC: assert property (($rose(tx_channel_ready) && !$past(tmr_mode_r)) |-> ($past(sender_verified_in, 4) || $past(sender_verified_in, 5)))
		else $error("tx ready before partner verified");
endmodule // sli_endpoint_sva

bind sli_endpoint sli_endpoint_sva #(.LANES(LANES)) u_sva (.*);

// ### verification/sli_partner_model.sv
// Purpose: back channel from the far receiver to the sender sideband
// Assumes: partner status is in the user clock domain
// Notes:   slow adds three cycles of channel latency
module sli_partner_model (
	input  logic clk,
	input  logic slow,
	input  logic receiver_lanes_aligned_out,
	input  logic receiver_bonding_out,
	input  logic receiver_verified_out,
	input  logic receiver_restart_out,
	output logic sender_lanes_aligned_in,
	output logic sender_bonding_in,
	output logic sender_verified_in,
	output logic sender_restart_in
);
	logic [15:0] sh_r = 16'h0;

	always @(posedge clk) begin
		sh_r <= {sh_r[11:0], receiver_lanes_aligned_out, receiver_bonding_out, receiver_verified_out, receiver_restart_out};
	end
	// each status is relayed only once the receiver shows it; restart lasts as long as the receiver holds it
	assign {sender_lanes_aligned_in, sender_bonding_in, sender_verified_in, sender_restart_in} =
		slow ? sh_r[15:12] : sh_r[3:0];
endmodule // sli_partner_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the simplex link endpoint
// Assumes: partner relays receiver status back to the sender
// Notes:   short timer parameters keep the run brief
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LANES = 2;
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic tx_system_reset = 1'h0, rx_system_reset = 1'h0, power_down_in = 1'h0, slow = 1'h1;
	logic tx_hard_err_in = 1'h0, rx_hard_err_in = 1'h0, tx_user_valid_in = 1'h0, rx_user_valid_in = 1'h0;
	logic rx_bond_done_in = 1'h0, rx_verify_done_in = 1'h0, rx_frame_err_in = 1'h0;
	logic avs_read = 1'h0, avs_write = 1'h0;
	logic [0:LANES-1] tx_gt_lane_ok = 2'h0, rx_gt_lane_locked = 2'h0, rx_code_err_in = 2'h0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, gt_power_down, tx_channel_ready, tx_send_enable, rx_channel_ready, rx_user_valid;
	wire receiver_lanes_aligned_out, receiver_bonding_out, receiver_verified_out, receiver_restart_out;
	wire sender_lanes_aligned_in, sender_bonding_in, sender_verified_in, sender_restart_in;
	wire rx_soft_err, rx_frame_err;
	wire [0:LANES-1] tx_lane_ready, rx_lane_ready;
	int n_mismatch = 0, checks = 0, cyc = 0;

	sli_endpoint #(.LANES(LANES), .ALIGN_CYC(8), .BOND_CYC(8), .VERIFY_CYC(8), .REINIT_CYC(64), .WDOG_CYC(40)) dut (.*);
	sli_partner_model u_partner (.*);

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		d = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clk);
	endtask

	task automatic wait_both();
		int n;
		n = 0;
		while (!(tx_channel_ready === 1'h1 && rx_channel_ready === 1'h1) && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk(n < 300, 32'h1, "channels up");
	endtask

	task automatic t_bring_up();
		rx_gt_lane_locked <= 2'h3;
		tx_gt_lane_ok <= 2'h3;
		repeat (12) @(posedge clk);
		chk({receiver_lanes_aligned_out, receiver_bonding_out, receiver_verified_out, rx_channel_ready}, 4'h8, "aligned");
		chk(tx_channel_ready, 1'h0, "tx waits for verify");
		rx_bond_done_in <= 1'h1;
		repeat (3) @(posedge clk);
		chk({receiver_bonding_out, receiver_verified_out, rx_channel_ready}, 3'h4, "bonded");
		rx_verify_done_in <= 1'h1;
		wait_both();
		chk({rx_lane_ready, tx_lane_ready, receiver_verified_out, receiver_restart_out}, 6'h3e, "lanes up");
	endtask

	task automatic t_data();
		tx_user_valid_in <= 1'h1;
		rx_user_valid_in <= 1'h1;
		repeat (3) @(posedge clk);
		chk({tx_send_enable, rx_user_valid}, 2'h3, "data passes");
		rx_gt_lane_locked <= 2'h2;
		repeat (4) @(posedge clk);
		chk({rx_user_valid, receiver_lanes_aligned_out, receiver_restart_out}, 3'h1, "lane lost");
		repeat (8) @(posedge clk);
		chk({tx_channel_ready, tx_send_enable}, 2'h0, "tx restarted");
		tx_user_valid_in <= 1'h0;
		rx_user_valid_in <= 1'h0;
		rx_gt_lane_locked <= 2'h3;
		slow <= 1'h0;
		wait_both();
	endtask

	task automatic t_errs();
		rx_frame_err_in <= 1'h1;
		rx_code_err_in <= 2'h1;
		@(posedge clk);
		rx_frame_err_in <= 1'h0;
		rx_code_err_in <= 2'h2;
		@(posedge clk);
		rx_code_err_in <= 2'h0;
		chk({rx_frame_err, rx_soft_err}, 2'h3, "first error");
		@(posedge clk);
		chk({rx_frame_err, rx_soft_err}, 2'h1, "second error");
		@(posedge clk);
		chk({rx_frame_err, rx_soft_err}, 2'h0, "errors over");
		bus(1'h0, 4'hc, 32'h0, rd);
		chk(rd, 32'h2, "soft count");
		bus(1'h1, 4'hc, 32'h0, rd);
		bus(1'h0, 4'hc, 32'h0, rd);
		chk(rd, 32'h0, "count cleared");
		rx_code_err_in <= 2'h1;
		bus(1'h1, 4'hc, 32'h0, rd);
		rx_code_err_in <= 2'h0;
		repeat (2) @(posedge clk);
		bus(1'h0, 4'hc, 32'h0, rd);
		chk(rd, 32'h3, "error wins clear");
	endtask

	task automatic t_dirs();
		for (int k = 0; k < 4; k++) begin
			tx_system_reset <= (k == 0);
			tx_hard_err_in <= (k == 1);
			rx_system_reset <= (k == 2);
			rx_hard_err_in <= (k == 3);
			@(posedge clk);
			{tx_system_reset, tx_hard_err_in, rx_system_reset, rx_hard_err_in} <= 4'h0;
			repeat (2) @(posedge clk);
			chk({tx_channel_ready, rx_channel_ready}, (k < 2) ? 2'h1 : 2'h2, "one side restarts");
			wait_both();
		end
	endtask

	task automatic t_bus();
		power_down_in <= 1'h1;
		bus(1'h0, 4'h4, 32'h0, rd);
		chk(rd, 32'h441f, "status");
		chk(gt_power_down, 1'h1, "power down on");
		power_down_in <= 1'h0;
		bus(1'h0, 4'h8, 32'h0, rd);
		chk(rd, 32'h30003, "lane map");
		chk(gt_power_down, 1'h0, "power down off");
		bus(1'h1, 4'h2, 32'hffffffff, rd);
		bus(1'h0, 4'h2, 32'h0, rd);
		chk(rd, 32'h0, "unmapped");
		bus(1'h1, 4'h0, 32'h2, rd);
		repeat (2) @(posedge clk);
		chk(tx_channel_ready, 1'h0, "forced restart");
		bus(1'h0, 4'h0, 32'h0, rd);
		chk(rd, 32'h2, "control");
		bus(1'h1, 4'h0, 32'h0, rd);
		wait_both();
	endtask

	task automatic t_timer();
		bus(1'h1, 4'h0, 32'h3, rd);
		bus(1'h1, 4'h0, 32'h5, rd);
		repeat (27) @(posedge clk);
		chk(tx_channel_ready, 1'h0, "timers still running");
		@(posedge clk);
		chk(tx_channel_ready, 1'h1, "timer bring-up");
		repeat (64) @(posedge clk);
		chk(tx_channel_ready, 1'h1, "up until reinit");
		@(posedge clk);
		chk(tx_channel_ready, 1'h0, "periodic reinit");
		chk(rx_channel_ready, 1'h1, "rx unaffected");
		bus(1'h1, 4'h0, 32'h0, rd);
		wait_both();
	endtask

	initial begin
		repeat (16) @(posedge clk);
		chk({avs_waitrequest, receiver_restart_out, tx_channel_ready, rx_channel_ready}, 4'hc, "in reset");
		reset <= 1'h0;
		t_bring_up();
		t_data();
		t_errs();
		t_dirs();
		t_bus();
		t_timer();
		stop_test();
	end
endmodule // tb_top
